// ---- bench/crm_bank_model.sv ----
// register bank model answering the handler's access strobes
// assumes reg_num holds steady while its answer is sampled
`timescale 1ns/1ps
module crm_bank_model (
  input  wire        clk_sys,
  input  wire [15:0] reg_num,
  input  wire        reg_wr,
  input  wire [31:0] reg_wdata,
  output wire [31:0] reg_rdata,
  output wire        reg_ok
);
  reg [31:0] mem [0:3];
  // only four words exist, so higher numbers report a failure
  assign reg_ok    = reg_num < 16'h0004;
  assign reg_rdata = reg_ok ? mem[reg_num[1:0]] : ~mem[0];
  always @(posedge clk_sys) begin
    if (reg_wr && reg_ok) begin
      mem[reg_num[1:0]] <= reg_wdata;
    end
  end
endmodule // crm_bank_model

// ---- bench/crm_handler_chk.sv ----
// checker watching the handler's ports only
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ps
module crm_handler_chk (
  input logic        clk_sys,
  input logic        rst_n,
  input logic        rx_ready,
  input logic        tx_valid,
  input logic        tx_ready,
  input logic [8:0]  tx_token,
  input logic [23:0] tx_dest,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_num,
  input logic [15:0] reg_ps_id,
  input logic        reg_ok
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_ps_id_form: assert property ((reg_wr || reg_rd) |->
    reg_ps_id == {reg_num[7:0], 8'h0B}) else $error("bad ps id");
  a_wr_one_pulse: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe too long");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_token)) else $error("reply token dropped");
  a_rx_blocked: assert property ((reg_wr || reg_rd) |-> !rx_ready)
    else $error("request taken during access");
  a_reply_alone: assert property (tx_valid |-> !rx_ready)
    else $error("request open while reply pending");
  a_rd_reply: assert property (reg_rd |-> ##[1:20] tx_valid &&
    (tx_token == 9'h103 || tx_token == 9'h104)) else $error("no read reply");
  a_rd_fail: assert property (reg_rd ##1 !reg_ok |-> ##[0:20]
    tx_valid && tx_token == 9'h104) else $error("no read failure");
  a_wr_ack: assert property (reg_wr && tx_dest[7:0] != 8'hFF ##1 reg_ok
    |-> ##[0:20] tx_valid && tx_token == 9'h103) else $error("no write ack");
  a_no_reply: assert property (reg_wr && tx_dest[7:0] == 8'hFF |->
    !tx_valid [*8]) else $error("reply not suppressed");
endmodule // crm_handler_chk

bind crm_handler crm_handler_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_token(tx_token), .tx_dest(tx_dest), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_num(reg_num), .reg_ps_id(reg_ps_id), .reg_ok(reg_ok));

// ---- bench/crm_handler_tb.sv ----
// testbench: tasks play the requesting channel-end
// assumes crm_bank_model behind the register port
`timescale 1ns/1ps
module crm_handler_tb;
  reg         clk_sys = 0;
  reg         rst_n = 0;
  reg         rx_valid = 0;
  reg  [8:0]  rx_token = 9'h000;
  reg         tx_ready = 1;
  reg         stall = 0;
  wire        rx_ready, tx_valid, reg_wr, reg_rd, reg_ok;
  wire [8:0]  tx_token;
  wire [23:0] tx_dest;
  wire [15:0] reg_num, reg_ps_id;
  wire [31:0] reg_wdata, reg_rdata;
  integer     n_mismatch = 0;
  integer     compares = 0;
  reg  [8:0]  rq[$];

  crm_handler DUT (.clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_token(rx_token), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_token(tx_token), .tx_dest(tx_dest),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_num(reg_num),
    .reg_ps_id(reg_ps_id), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ok(reg_ok));
  crm_bank_model u_bank (.clk_sys(clk_sys), .reg_num(reg_num),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ok(reg_ok));

  always #2 clk_sys = ~clk_sys;
  // a stalling receiver accepts only every other cycle
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) rq.push_back(tx_token);
    tx_ready <= #1 stall ? ~tx_ready : 1'b1;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task put(input [8:0] t);
    integer i;
    begin
      rx_valid = 1;
      rx_token = t;
      i = 0;
      @(posedge clk_sys);
      while (rx_ready !== 1'b1 && i < 100) begin
        i = i + 1;
        @(posedge clk_sys);
      end
      #1;
    end
  endtask
  task msg(input [8:0] op, input [23:0] ret, input [15:0] n, input [31:0] d);
    integer k;
    begin
      put(op);
      for (k = 2; k >= 0; k = k - 1) put({1'b0, ret[8*k +: 8]});
      for (k = 1; k >= 0; k = k - 1) put({1'b0, n[8*k +: 8]});
      if (op == 9'h1C0)
        for (k = 3; k >= 0; k = k - 1) put({1'b0, d[8*k +: 8]});
      put(9'h101);
      rx_valid = 0;
    end
  endtask
  task reply(input integer n, input [53:0] e);
    integer i;
    begin
      i = 0;
      while (rq.size() < n && i < 200) begin
        i = i + 1;
        @(posedge clk_sys);
      end
      repeat (20) @(posedge clk_sys);
      chk(rq.size(), n);
      for (i = 0; i < n; i = i + 1) chk(rq[i], e[9*(n-1-i) +: 9]);
      rq = {};
      #1;
    end
  endtask
  task stop_test;
    begin
      if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_write_ok;
    begin
      msg(9'h1C0, 24'h0A0B0C, 16'h0002, 32'h12345678);
      reply(2, {9'h103, 9'h101});
      chk(tx_dest, 24'h0A0B0C);
      chk(reg_ps_id, 16'h020B);
    end
  endtask
  task t_read_stall;
    begin
      stall = 1;
      msg(9'h1C1, 24'h0A0B0C, 16'h0002, 32'h00000000);
      reply(6, {9'h103, 9'h012, 9'h034, 9'h056, 9'h078, 9'h101});
      stall = 0;
    end
  endtask
  task t_quiet_write;
    begin
      msg(9'h1C0, 24'h0A0BFF, 16'h0001, 32'hCAFEF00D);
      reply(0, 54'h0);
      msg(9'h1C1, 24'h0A0B0C, 16'h0001, 32'h00000000);
      reply(6, {9'h103, 9'h0CA, 9'h0FE, 9'h0F0, 9'h00D, 9'h101});
    end
  endtask
  task t_fail;
    begin
      msg(9'h1C1, 24'h0A0B0C, 16'h0109, 32'h00000000);
      reply(2, {9'h104, 9'h101});
      msg(9'h1C0, 24'h0A0B0C, 16'h0109, 32'h00000001);
      reply(2, {9'h104, 9'h101});
    end
  endtask
  task t_malformed;
    integer k;
    begin
      // a control token inside the return field, full length otherwise
      put(9'h1C0);
      put(9'h00A);
      put(9'h10B);
      put(9'h00C);
      for (k = 0; k < 6; k = k + 1) put(9'h001);
      put(9'h101);
      rx_valid = 0;
      reply(2, {9'h104, 9'h101});
      // a read closed by a data token instead of the closing token
      put(9'h1C1);
      for (k = 0; k < 5; k = k + 1) put(9'h001);
      put(9'h0AA);
      rx_valid = 0;
      reply(2, {9'h104, 9'h101});
    end
  endtask

  initial begin
    #40000;
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1;
    @(posedge clk_sys);
    #1;
    t_write_ok;
    t_read_stall;
    t_quiet_write;
    t_fail;
    t_malformed;
    stop_test;
  end
endmodule // crm_handler_tb

// ---- rtl/crm_defines.vh ----
// constants for the configuration register message handler
// assumes a token stream of 9-bit symbols: bit 8 marks a control token
`ifndef CRM_DEFINES_VH
`define CRM_DEFINES_VH
`define CRM_TOK_WRITE   8'hC0
`define CRM_TOK_READ    8'hC1
`define CRM_TOK_END     8'h01
`define CRM_TOK_ACK     8'h03
`define CRM_TOK_NACK    8'h04
`define CRM_NOREPLY     8'hFF
`define CRM_CTRL_BIT    8
`define CRM_PS_SHIFT    8
`define CRM_PS_TYPE     8'h0B
`define CRM_RET_BYTES   3
`define CRM_REG_BYTES   2
`define CRM_DATA_BYTES  4
`endif

// ---- rtl/crm_handler.v ----
// message handler for configuration register banks
// assumes a 9-bit token stream in and out, and a register port that
// answers a read or write in the same cycle as its strobe
`timescale 1ns/1ps
`include "crm_defines.vh"

module crm_handler (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        rx_valid,
  output reg         rx_ready,
  input  wire [8:0]  rx_token,
  output reg         tx_valid,
  input  wire        tx_ready,
  output reg  [8:0]  tx_token,
  output reg  [23:0] tx_dest,
  output reg         reg_wr,
  output reg         reg_rd,
  output reg  [15:0] reg_num,
  output reg  [15:0] reg_ps_id,
  output reg  [31:0] reg_wdata,
  input  wire [31:0] reg_rdata,
  input  wire        reg_ok
);
  // ****************************************
  // states
  // ****************************************
  localparam S_IDLE = 3'h0;
  localparam S_RET  = 3'h1;
  localparam S_NUM  = 3'h2;
  localparam S_DATA = 3'h3;
  localparam S_END  = 3'h4;
  localparam S_ACC  = 3'h5;
  localparam S_WAIT = 3'h6;
  localparam S_REP  = 3'h7;

  reg  [2:0]  state;
  reg  [2:0]  cnt;
  reg         is_read;
  reg         bad;
  reg  [23:0] ret;
  reg  [15:0] num;
  reg  [31:0] data;
  reg  [2:0]  rep_len;
  reg  [2:0]  rep_idx;
  reg         ok;
  reg         b_valid;
  reg  [8:0]  b_token;
  wire        b_ready;
  wire        o_valid;
  wire [8:0]  o_token;
  wire        rx_take;
  wire        rx_ctrl;

  assign rx_take = rx_valid & rx_ready;
  assign rx_ctrl = rx_token[`CRM_CTRL_BIT];

  function [8:0] ctl;
    input [7:0] v;
    ctl = {1'b1, v};
  endfunction

  // ****************************************
  // reply token selection
  // ****************************************
  always @* begin
    b_token = ctl(`CRM_TOK_END);
    if (rep_idx == 3'h0)
      b_token = ctl(ok ? `CRM_TOK_ACK : `CRM_TOK_NACK);
    else if (rep_idx < rep_len - 3'h1)
      case (rep_idx)
        3'h1:    b_token = {1'b0, data[31:24]};
        3'h2:    b_token = {1'b0, data[23:16]};
        3'h3:    b_token = {1'b0, data[15:8]};
        default: b_token = {1'b0, data[7:0]};
      endcase
  end

  // ****************************************
  // request parser and sequencer
  // ****************************************
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state     <= S_IDLE;
      cnt       <= 3'h0;
      is_read   <= 1'b0;
      bad       <= 1'b0;
      ret       <= 24'h000000;
      num       <= 16'h0000;
      data      <= 32'h00000000;
      rep_len   <= 3'h0;
      rep_idx   <= 3'h0;
      ok        <= 1'b0;
      rx_ready  <= 1'b0;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_num   <= 16'h0000;
      reg_ps_id <= 16'h0000;
      reg_wdata <= 32'h00000000;
      tx_dest   <= 24'h000000;
      b_valid   <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      case (state)
        S_IDLE: begin
          // reopen only once the last reply has left, so tx_dest
          // cannot change under a reply still waiting in the buffer
          rx_ready <= ~(o_valid | tx_valid);
          bad      <= 1'b0;
          cnt      <= 3'h0;
          if (rx_take && rx_ctrl) begin
            if (rx_token[7:0] == `CRM_TOK_WRITE ||
                rx_token[7:0] == `CRM_TOK_READ) begin
              is_read <= (rx_token[7:0] == `CRM_TOK_READ);
              state   <= S_RET;
            end
          end
        end
        S_RET: if (rx_take) begin
          if (rx_ctrl)
            bad <= 1'b1;
          ret <= {ret[15:0], rx_token[7:0]};
          cnt <= cnt + 3'h1;
          if (cnt == `CRM_RET_BYTES - 1) begin
            cnt   <= 3'h0;
            state <= S_NUM;
          end
        end
        S_NUM: if (rx_take) begin
          if (rx_ctrl)
            bad <= 1'b1;
          num <= {num[7:0], rx_token[7:0]};
          cnt <= cnt + 3'h1;
          if (cnt == `CRM_REG_BYTES - 1) begin
            cnt   <= 3'h0;
            state <= is_read ? S_END : S_DATA;
          end
        end
        S_DATA: if (rx_take) begin
          if (rx_ctrl)
            bad <= 1'b1;
          data <= {data[23:0], rx_token[7:0]};
          cnt  <= cnt + 3'h1;
          if (cnt == `CRM_DATA_BYTES - 1)
            state <= S_END;
        end
        S_END: if (rx_take) begin
          rx_ready <= 1'b0;
          if (!rx_ctrl || rx_token[7:0] != `CRM_TOK_END || bad) begin
            // malformed message: answer with failure unless a write with return byte FF, no access
            ok    <= 1'b0;
            state <= S_WAIT;
          end else
            state <= S_ACC;
          tx_dest <= ret;
        end
        S_ACC: begin
          reg_num   <= num;
          reg_ps_id <= {num[7:0], `CRM_PS_TYPE};
          reg_wdata <= data;
          reg_wr    <= ~is_read;
          reg_rd    <= is_read;
          state     <= S_WAIT;
          cnt       <= 3'h1;
        end
        S_WAIT: begin
          // cnt marks an access in flight, answered one cycle on
          if (cnt == 3'h1) begin
            cnt  <= 3'h0;
            if (reg_ok) begin
              ok <= 1'b1;
              if (is_read)
                data <= reg_rdata;
            end else
              ok <= 1'b0;
          end else begin
            rep_idx <= 3'h0;
            rep_len <= (is_read && ok) ? 3'h6 : 3'h2;
            if (!is_read && ret[7:0] == `CRM_NOREPLY) begin
              state <= S_IDLE;
            end else begin
              b_valid <= 1'b1;
              state   <= S_REP;
            end
          end
        end
        S_REP: if (b_valid && b_ready) begin
          rep_idx <= rep_idx + 3'h1;
          if (rep_idx == rep_len - 3'h1) begin
            b_valid <= 1'b0;
            state   <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // reply buffer; a stalled receiver loses nothing
  // ****************************************
  crm_skid #(
    .WIDTH (9)
  ) u_skid (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (b_valid),
    .in_ready  (b_ready),
    .in_data   (b_token),
    .out_valid (o_valid),
    .out_ready (~tx_valid | tx_ready),
    .out_data  (o_token)
  );

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_token <= 9'h000;
    end else if (~tx_valid | tx_ready) begin
      tx_valid <= o_valid;
      tx_token <= o_token;
    end
  end
endmodule // crm_handler

// ---- rtl/crm_skid.v ----
// two-entry buffer with valid and ready on both sides
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module crm_skid #(
  parameter WIDTH = 9
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:1];
  reg             wr_ptr;
  reg             rd_ptr;
  reg [1:0]       count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // crm_skid
